/* bench/gpcde_pins_model.sv */
// Board-side model of the port C, D and E pins
`timescale 1ns/1ps
module gpcde_pins_model (
  // Pad drive from the block
  input  wire logic [7:0] cOut,
  input  wire logic [7:0] cOe,
  input  wire logic [7:0] dOut,
  input  wire logic [7:0] dOe,
  input  wire logic [2:0] eOut,
  input  wire logic [2:0] eOe,
  // Levels the board puts on undriven pins
  input  wire logic [7:0] cExt,
  input  wire logic [7:0] dExt,
  input  wire logic [2:0] eExt,
  // Resolved wire levels
  output logic      [7:0] cPin,
  output logic      [7:0] dPin,
  output logic      [2:0] ePin
);
  // ==========================================================
  // Wire resolution
  // A driven pad wins; otherwise the board source sets the level
  assign cPin = (cOe & cOut) | (~cOe & cExt);
  assign dPin = (dOe & dOut) | (~dOe & dExt);
  assign ePin = (eOe & eOut) | (~eOe & eExt);
endmodule

/* bench/gpio_ports_c_d_e_tb.sv */
// Register-level testbench for the port C, D and E block
`timescale 1ns/1ps
module gpio_ports_c_d_e_tb
  import gpcde_pkg::*;
;
  logic                clock, rst, softRst, psel, penable, pwrite;
  logic [GPCDE_AW-1:0] paddr;
  logic [GPCDE_DW-1:0] pwdata, prdata, rdat;
  logic                pready, pslverr, rerr;
  logic [7:0]          cPin, cOut, cOe, ovrEn, ovrIn, ovrOut, cExt;
  logic [7:0]          dPin, dOut, dOe, slvData, slvIn, dExt;
  logic [2:0]          ePin, eOut, eOe, eExt;
  logic                slvDrive, inFull, outFull, ovfSet, slvSel;
  int                  bad_count, total_checks;

  gpcde_ports i_dut (
    .clock(clock), .rst(rst), .softRst(softRst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .portCIn(cPin), .portCOut(cOut), .portCOe(cOe),
    .periphOvrEn(ovrEn), .periphOvrIsInput(ovrIn),
    .periphOvrOut(ovrOut), .portDIn(dPin), .portDOut(dOut),
    .portDOe(dOe), .portEIn(ePin), .portEOut(eOut), .portEOe(eOe),
    .slaveOutData(slvData), .slaveDrive(slvDrive),
    .slaveInputFull(inFull), .slaveOutputFull(outFull),
    .slaveOverflowSet(ovfSet), .slavePortSelect(slvSel),
    .slaveInData(slvIn)
  );

  gpcde_pins_model i_pins (
    .cOut(cOut), .cOe(cOe), .dOut(dOut), .dOe(dOe), .eOut(eOut),
    .eOe(eOe), .cExt(cExt), .dExt(dExt), .eExt(eExt), .cPin(cPin),
    .dPin(dPin), .ePin(ePin)
  );

  // ==========================================================
  // Clock and watchdog
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    #100000;
    bad_count++;
    print_verdict();
  end

  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; waits for pready as long as it takes
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rdat    = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a);
    xfer(1'b0, a, 32'h0);
  endtask

  // Lets pads update and pin levels pass the synchroniser
  task automatic settle();
    repeat (4) @(posedge clock);
    #1;
  endtask

  task automatic done(input string name);
    $display("test %s done", name);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ==========================================================
  // Tests
  initial begin
    rst = 1'b1; softRst = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
    ovrEn = 8'h00; ovrIn = 8'h00; ovrOut = 8'h00; slvData = 8'h96;
    slvDrive = 1'b0; inFull = 1'b0; outFull = 1'b0; ovfSet = 1'b0;
    cExt = 8'h00; dExt = 8'h3c; eExt = 3'h7;
    bad_count = 0; total_checks = 0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    settle();
    chk({8'h0, cOe, dOe, 5'h0, eOe}, 32'h0);
    rd(OFF_C_DIR); chk(rdat, 32'hff);
    rd(OFF_D_DIR); chk(rdat, 32'hff);
    rd(OFF_E_CTRL); chk(rdat, 32'h07);
    rd(OFF_E_ANA); chk(rdat, 32'h07);
    done("reset");
    wr(OFF_D_LATCH, 32'ha5);
    wr(OFF_D_DIR, 32'h0f);
    settle();
    chk({24'h0, dOe}, 32'hf0);
    chk({24'h0, dOut & 8'hf0}, 32'ha0);
    rd(OFF_D_PINS); chk(rdat, 32'hac);
    chk({24'h0, slvIn}, 32'hac);
    rd(OFF_D_LATCH); chk(rdat, 32'ha5);
    wr(OFF_D_PINS, 32'h5a);
    rd(OFF_D_LATCH); chk(rdat, 32'h5a);
    done("port_d");
    // Analog select cleared before any port E pin becomes an output
    wr(OFF_E_ANA, 32'h0);
    wr(OFF_E_LATCH, 32'h5);
    wr(OFF_E_CTRL, 32'h0);
    settle();
    chk({29'h0, eOe}, 32'h7);
    chk({29'h0, eOut}, 32'h5);
    rd(OFF_E_LATCH); chk(rdat, 32'h5);
    wr(OFF_E_CTRL, 32'h07);
    wr(OFF_E_ANA, 32'h2);
    settle();
    rd(OFF_E_PINS); chk(rdat, 32'h5);
    done("port_e");
    inFull <= 1'b1;
    wr(OFF_E_CTRL, 32'hff);
    slvDrive <= 1'b1;
    settle();
    rd(OFF_E_CTRL); chk(rdat, 32'h97);
    chk({31'h0, slvSel}, 32'h1);
    chk({16'h0, dOut, dOe}, 32'h96ff);
    // One overflow pulse, then a write of zero to bit 5 clears it
    ovfSet <= 1'b1;
    @(posedge clock);
    ovfSet <= 1'b0;
    rd(OFF_E_CTRL); chk(rdat, 32'hb7);
    wr(OFF_E_CTRL, 32'h07);
    slvDrive <= 1'b0;
    inFull <= 1'b0;
    rd(OFF_E_CTRL); chk(rdat, 32'h07);
    done("slave");
    wr(OFF_C_LATCH, 32'h33);
    wr(OFF_C_DIR, 32'h00);
    ovrEn <= 8'h03;
    ovrIn <= 8'h01;
    settle();
    chk({16'h0, cOe, cOe & cOut}, 32'hfe30);
    rd(OFF_C_DIR); chk(rdat, 32'h00);
    done("port_c");
    softRst <= 1'b1;
    @(posedge clock);
    softRst <= 1'b0;
    rd(OFF_D_LATCH); chk(rdat, 32'h5a);
    rd(OFF_C_LATCH); chk(rdat, 32'h33);
    rd(OFF_D_DIR); chk(rdat, 32'hff);
    done("soft_reset");
    wr(12'h0fc, 32'hff);
    chk({31'h0, rerr}, 32'h1);
    rd(12'h0fc); chk({rerr, rdat[30:0]}, 32'h80000000);
    done("unmapped");
    print_verdict();
  end
endmodule

/* core/gpcde_pad.sv */
// Per-pin driver selection with peripheral override
`timescale 1ns/1ps
module gpcde_pad
  import gpcde_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Software view
  input  wire logic [WIDTH-1:0] latch,
  input  wire logic [WIDTH-1:0] dir,
  // Peripheral override
  input  wire logic [WIDTH-1:0] ovrEn,
  input  wire logic [WIDTH-1:0] ovrIsInput,
  input  wire logic [WIDTH-1:0] ovrOut,
  // Pad drive
  output logic      [WIDTH-1:0] padOut,
  output logic      [WIDTH-1:0] padOe
);

  // ==========================================================
  // Direction 1 floats the pin, 0 drives the latch
  for (genvar i = 0; i < WIDTH; i++) begin : g_pin
    always_comb begin
      if (ovrEn[i]) begin
        padOut[i] = ovrOut[i];
        padOe[i]  = ~ovrIsInput[i];
      end else begin
        padOut[i] = latch[i];
        padOe[i]  = ~dir[i];
      end
    end
  end

endmodule

/* core/gpcde_pkg.sv */
// Shared constants for the port C, D and E block
package gpcde_pkg;

  // ==========================================================
  // Bus geometry
  localparam int         GPCDE_AW   = 12;
  localparam int         GPCDE_DW   = 32;

  // ==========================================================
  // Register byte offsets
  localparam logic [11:0] OFF_C_PINS  = 12'h000;
  localparam logic [11:0] OFF_C_LATCH = 12'h004;
  localparam logic [11:0] OFF_C_DIR   = 12'h008;
  localparam logic [11:0] OFF_D_PINS  = 12'h00c;
  localparam logic [11:0] OFF_D_LATCH = 12'h010;
  localparam logic [11:0] OFF_D_DIR   = 12'h014;
  localparam logic [11:0] OFF_E_PINS  = 12'h018;
  localparam logic [11:0] OFF_E_LATCH = 12'h01c;
  localparam logic [11:0] OFF_E_CTRL  = 12'h020;
  localparam logic [11:0] OFF_E_ANA   = 12'h024;

  // ==========================================================
  // Port E direction and slave control field positions
  localparam int BIT_IN_FULL  = 7;
  localparam int BIT_OUT_FULL = 6;
  localparam int BIT_IN_OVF   = 5;
  localparam int BIT_SLV_SEL  = 4;

  // ==========================================================
  // Values after reset
  localparam logic [7:0] RST_DIR_CD  = 8'hff;
  localparam logic [2:0] RST_DIR_E   = 3'h7;
  localparam logic [7:0] RST_CTRL_E  = 8'h07;
  localparam logic [2:0] RST_ANA_E   = 3'h7;
  localparam logic [7:0] RST_LATCH   = 8'h00;

  // ==========================================================
  // Pin synchroniser depth
  localparam int SYNC_STAGES = 2;

endpackage

/* core/gpcde_ports.sv */
// APB-attached general-purpose ports C, D and E
//
// What this block does
// - Port D direction bit 1 floats that pin as an input.
// - Port D direction bit 0 drives the latch bit onto the pin.
// - Port D latch is mapped; reads return latch, not pin level.
// - Each port D pin has its own direction bit; resets to all ones.
// - Slave select bit 4 of port E control turns port D into slave port.
// - In slave mode, port D pin n carries slave data bit n.
// - Three port E pins; direction 1 floats, 0 drives the E latch.
// - Port E latch is mapped; reads return latch, not pins.
// - Port E pins selected as analog read back as zero.
// - Power-on reset selects all port E pins as analog.
// - Port E control resets to 0000 -111; bit 3 reads zero.
// - C and D pin and latch values are kept over other resets.
// - Power-on reset leaves every port D pin a digital input.
// - Port C direction works like the others: 1 input, 0 drive.
// - Peripheral overrides never get written into direction bits.
`timescale 1ns/1ps
module gpcde_ports
  import gpcde_pkg::*;
(
  // Clock and resets
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic                softRst,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [GPCDE_AW-1:0] paddr,
  input  wire logic [GPCDE_DW-1:0] pwdata,
  output logic      [GPCDE_DW-1:0] prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Port C pins
  input  wire logic [7:0]          portCIn,
  output logic      [7:0]          portCOut,
  output logic      [7:0]          portCOe,
  // Port C peripheral override
  input  wire logic [7:0]          periphOvrEn,
  input  wire logic [7:0]          periphOvrIsInput,
  input  wire logic [7:0]          periphOvrOut,
  // Port D pins
  input  wire logic [7:0]          portDIn,
  output logic      [7:0]          portDOut,
  output logic      [7:0]          portDOe,
  // Port E pins
  input  wire logic [2:0]          portEIn,
  output logic      [2:0]          portEOut,
  output logic      [2:0]          portEOe,
  // Parallel slave port data path
  input  wire logic [7:0]          slaveOutData,
  input  wire logic                slaveDrive,
  input  wire logic                slaveInputFull,
  input  wire logic                slaveOutputFull,
  input  wire logic                slaveOverflowSet,
  output logic                     slavePortSelect,
  output logic      [7:0]          slaveInData
);

  // ==========================================================
  // Decode helper
  function automatic logic hit(input logic [GPCDE_AW-1:0] a,
                               input logic [11:0]         off);
    hit = (a == off);
  endfunction

  // ==========================================================
  // State
  typedef struct packed {
    logic [7:0]  latchC;
    logic [7:0]  dirC;
    logic [7:0]  latchD;
    logic [7:0]  dirD;
    logic [2:0]  latchE;
    logic [2:0]  dirE;
    logic        slvSel;
    logic        slvOvf;
    logic [2:0]  analogE;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
    logic [7:0]  cOut;
    logic [7:0]  cOe;
    logic [7:0]  dOut;
    logic [7:0]  dOe;
    logic [2:0]  eOut;
    logic [2:0]  eOe;
  } gpcde_state_s;

  gpcde_state_s s;
  gpcde_state_s next_s;

  logic [7:0] pinC;
  logic [7:0] pinD;
  logic [2:0] pinE;
  logic [7:0] padCOut;
  logic [7:0] padCOe;
  logic [7:0] padDOut;
  logic [7:0] padDOe;
  logic [2:0] padEOut;
  logic [2:0] padEOe;
  logic       setup;
  logic       wrDone;
  logic [7:0] ctrlE;
  logic [7:0] padDEn;
  logic [7:0] padDIn;

  // ==========================================================
  // Pin synchronisers
  gpcde_sync #(.WIDTH(8)) u_sync_c (
    .clock  (clock),
    .rst    (rst),
    .async  (portCIn),
    .synced (pinC)
  );

  gpcde_sync #(.WIDTH(8)) u_sync_d (
    .clock  (clock),
    .rst    (rst),
    .async  (portDIn),
    .synced (pinD)
  );

  gpcde_sync #(.WIDTH(3)) u_sync_e (
    .clock  (clock),
    .rst    (rst),
    .async  (portEIn),
    .synced (pinE)
  );

  // ==========================================================
  // Pad drive, computed from the next register values
  // port C direction
  gpcde_pad #(.WIDTH(8)) u_pad_c (
    .latch      (next_s.latchC),
    .dir        (next_s.dirC),
    .ovrEn      (periphOvrEn),
    .ovrIsInput (periphOvrIsInput),
    .ovrOut     (periphOvrOut),
    .padOut     (padCOut),
    .padOe      (padCOe)
  );

  // slave mode hands port D to the slave data path
  assign padDEn = {8{next_s.slvSel}};
  assign padDIn = {8{~slaveDrive}};

  gpcde_pad #(.WIDTH(8)) u_pad_d (
    .latch      (next_s.latchD),
    .dir        (next_s.dirD),
    .ovrEn      (padDEn),
    .ovrIsInput (padDIn),
    .ovrOut     (slaveOutData),
    .padOut     (padDOut),
    .padOe      (padDOe)
  );

  gpcde_pad #(.WIDTH(3)) u_pad_e (
    .latch      (next_s.latchE),
    .dir        (next_s.dirE),
    .ovrEn      (3'h0),
    .ovrIsInput (3'h0),
    .ovrOut     (3'h0),
    .padOut     (padEOut),
    .padOe      (padEOe)
  );

  // ==========================================================
  // Bus handshake
  assign setup  = psel & ~penable;
  assign wrDone = psel & penable & s.ready & pwrite;

  // bit 3 is unimplemented and reads zero
  assign ctrlE = {slaveInputFull, slaveOutputFull, s.slvOvf, s.slvSel,
                  1'b0, s.dirE};

  // ==========================================================
  // Next state
  always_comb begin
    next_s       = s;
    next_s.ready = setup;
    next_s.err   = 1'b0;
    if (setup) begin
      next_s.rdata = '0;
      if (hit(paddr, OFF_C_PINS)) begin
        next_s.rdata[7:0] = pinC;
      end else if (hit(paddr, OFF_C_LATCH)) begin
        next_s.rdata[7:0] = s.latchC;
      end else if (hit(paddr, OFF_C_DIR)) begin
        next_s.rdata[7:0] = s.dirC;
      end else if (hit(paddr, OFF_D_PINS)) begin
        next_s.rdata[7:0] = pinD;
      end else if (hit(paddr, OFF_D_LATCH)) begin
        next_s.rdata[7:0] = s.latchD;
      end else if (hit(paddr, OFF_D_DIR)) begin
        next_s.rdata[7:0] = s.dirD;
      end else if (hit(paddr, OFF_E_PINS)) begin
        next_s.rdata[2:0] = pinE & ~s.analogE;
      end else if (hit(paddr, OFF_E_LATCH)) begin
        next_s.rdata[2:0] = s.latchE;
      end else if (hit(paddr, OFF_E_CTRL)) begin
        next_s.rdata[7:0] = ctrlE;
      end else if (hit(paddr, OFF_E_ANA)) begin
        next_s.rdata[2:0] = s.analogE;
      end else begin
        next_s.err = 1'b1;
      end
    end
    if (wrDone) begin
      // pin register writes land in the latch
      if (hit(paddr, OFF_C_PINS) || hit(paddr, OFF_C_LATCH)) begin
        next_s.latchC = pwdata[7:0];
      end else if (hit(paddr, OFF_C_DIR)) begin
        next_s.dirC = pwdata[7:0];
      end else if (hit(paddr, OFF_D_PINS) || hit(paddr, OFF_D_LATCH)) begin
        next_s.latchD = pwdata[7:0];
      end else if (hit(paddr, OFF_D_DIR)) begin
        next_s.dirD = pwdata[7:0];
      end else if (hit(paddr, OFF_E_PINS) || hit(paddr, OFF_E_LATCH)) begin
        next_s.latchE = pwdata[2:0];
      end else if (hit(paddr, OFF_E_CTRL)) begin
        next_s.slvSel = pwdata[BIT_SLV_SEL];
        next_s.dirE   = pwdata[2:0];
        if (!pwdata[BIT_IN_OVF]) begin
          next_s.slvOvf = 1'b0;
        end
      end else if (hit(paddr, OFF_E_ANA)) begin
        next_s.analogE = pwdata[2:0];
      end
    end
    // A new overflow outranks a clear in the same cycle
    if (slaveOverflowSet) begin
      next_s.slvOvf = 1'b1;
    end
    // other resets keep latches and pin state
    if (softRst) begin
      next_s.dirC   = RST_DIR_CD;
      next_s.dirD   = RST_DIR_CD;
      next_s.dirE   = RST_DIR_E;
      next_s.slvSel = 1'b0;
      next_s.slvOvf = 1'b0;
    end
    // overrides only steer pads, never the direction bits
    next_s.cOut = padCOut;
    next_s.cOe  = padCOe;
    next_s.dOut = padDOut;
    next_s.dOe  = padDOe;
    next_s.eOut = padEOut;
    next_s.eOe  = padEOe;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s         <= '0;
      s.latchC  <= RST_LATCH;
      s.latchD  <= RST_LATCH;
      s.latchE  <= RST_LATCH[2:0];
      s.dirC    <= RST_DIR_CD;
      s.dirD    <= RST_DIR_CD;
      s.dirE    <= RST_DIR_E;
      // power-on selects analog on port E
      s.analogE <= RST_ANA_E;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs
  assign prdata          = s.rdata;
  assign pready          = s.ready;
  assign pslverr         = s.err;
  assign portCOut        = s.cOut;
  assign portCOe         = s.cOe;
  assign portDOut        = s.dOut;
  assign portDOe         = s.dOe;
  assign portEOut        = s.eOut;
  assign portEOe         = s.eOe;
  assign slavePortSelect = s.slvSel;
  assign slaveInData     = pinD;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence latchDWrite;
    wrDone && (hit(paddr, OFF_D_LATCH) || hit(paddr, OFF_D_PINS));
  endsequence

  sequence latchDRead;
    setup && !pwrite && hit(paddr, OFF_D_LATCH);
  endsequence

  dir_d_float_a: assert property (
    !s.slvSel |-> ((portDOe & s.dirD) == 8'h00))
    else $error("port D input pin still driven");

  latch_d_drive_a: assert property (
    !s.slvSel |-> ((portDOut & ~s.dirD) == (s.latchD & ~s.dirD)))
    else $error("port D output not the latch");

  latch_d_read_a: assert property (
    latchDRead ##1 (penable && pready) |-> prdata == {24'h0, s.latchD})
    else $error("port D latch read wrong");

  pin_d_write_a: assert property (
    latchDWrite |=> s.latchD == $past(pwdata[7:0]))
    else $error("port D latch not written");

  soft_dir_a: assert property (
    softRst |=> s.dirD == RST_DIR_CD && s.dirC == RST_DIR_CD)
    else $error("direction not reset to input");

  ctrl_e_reset_a: assert property (
    softRst && !slaveInputFull && !slaveOutputFull
      |=> ctrlE == RST_CTRL_E || slaveInputFull || slaveOutputFull)
    else $error("port E control reset value wrong");

  analog_zero_a: assert property (
    setup && hit(paddr, OFF_E_PINS)
      |=> (prdata[2:0] & s.analogE) == 3'h0)
    else $error("analog pin read non-zero");

  slave_data_a: assert property (
    s.slvSel && $past(s.slvSel) |-> portDOut == $past(slaveOutData)
      && portDOe == {8{$past(slaveDrive)}})
    else $error("slave data not on port D");

  dir_e_a: assert property (
    ##1 portEOe == ~s.dirE)
    else $error("port E drive mismatch");

  ovr_keep_dir_a: assert property (
    periphOvrEn != 8'h00 && !wrDone && !softRst |=> $stable(s.dirC))
    else $error("override leaked into direction");

endmodule

/* core/gpcde_sync.sv */
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module gpcde_sync
  import gpcde_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // Data
  input  wire logic [WIDTH-1:0] async,
  output logic      [WIDTH-1:0] synced
);

  // ==========================================================
  // Stages
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } gpcde_sync_s;

  gpcde_sync_s s;
  gpcde_sync_s next_s;

  // The first stage feeds only the second
  always_comb begin
    next_s        = s;
    next_s.meta   = async;
    next_s.stable = s.meta;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign synced = s.stable;

endmodule
